// File: dv/seb_master.sv
// Two-wire bus master model: drives SCL, pulls SDA low, samples the wire.
// Assumes the bench resolves SDA with a pull-up; SCL idles high between frames.
`timescale 1ns/1ps
module seb_master (
	output logic      scl,
	output logic      sdaLow,
	input  wire logic sdaWire
);
	// Quarter bit; keeps each SCL phase well over six link clocks
	localparam int TQ = 80;
	initial
	begin
		scl    = 1'b1;
		sdaLow = 1'b0;
	end
	////////////////////////////////////////
	// Also serves as repeated START
	task automatic start();
		sdaLow = 1'b0;
		#TQ scl = 1'b1;
		#TQ sdaLow = 1'b1;
		#TQ scl = 1'b0;
		#TQ;
	endtask : start
	task automatic stop();
		sdaLow = 1'b1;
		#TQ scl = 1'b1;
		#TQ sdaLow = 1'b0;
		#TQ;
	endtask : stop
	// SDA only moves while SCL is low
	task automatic clkBit(input logic drvLow, output logic seen);
		sdaLow = drvLow;
		#TQ scl = 1'b1;
		#TQ seen = sdaWire;
		#TQ scl = 1'b0;
		#TQ;
	endtask : clkBit
	task automatic wByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clkBit(~b[i], s);
		clkBit(1'b0, s);
		ack = ~s;
	endtask : wByte
	// ackIt low ends a read with NoACK
	task automatic rByte(input logic ackIt, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			clkBit(1'b0, b[i]);
		clkBit(ackIt, s);
	endtask : rByte
endmodule : seb_master

// File: dv/test_seb_access.sv
// Self-checking bench of the serial EEPROM bank access block.
// Assumes seb_master on the bus and a pull-up resolving the data wire.
`timescale 1ns/1ps
module test_seb_access
	import seb_pkg::*;
();
	// Long enough that a polled address byte lands inside the write cycle
	localparam int WRC = 600;
	logic           clk_sys  = 1'b0;
	logic           clk_link = 1'b0;
	logic           resetn   = 1'b0;
	logic           hv       = 1'b0;
	logic [2:0]     addrPins = 3'h0;
	logic           expBank  = 1'b0;
	logic           scl;
	logic           sdaLow;
	wire            sdaWire;
	seb_pins_t      pins;
	seb_sda_drive_t sdaDrive;
	logic           activeBank;
	logic [3:0]     protectFlags;
	logic           writeBusy;
	logic [7:0]     tsPointer;
	logic [15:0]    tsData;
	logic [7:0]     mem [MEM_BYTES];
	logic [31:0]    rng = 32'h0000C5A9;
	logic           a;
	logic [7:0]     d;
	logic [15:0]    w;
	int             n_mismatch = 0;
	int             tests_run  = 0;
	int             busyLen    = 0;
	assign sdaWire = ~(sdaLow | (sdaDrive.sdaOe & ~sdaDrive.sdaOut));
	assign pins    = '{hv: hv, addr: addrPins, sda: sdaWire, scl: scl};
	always #5 clk_sys = ~clk_sys;
	always #6 clk_link = ~clk_link;
	always @(posedge clk_sys)
		if (writeBusy === 1'b1)
			busyLen <= busyLen + 1;
	seb_access #(.WR_CYCLES(WRC)) dut (
		.clk_sys(clk_sys), .resetn(resetn), .clk_link(clk_link), .pins(pins),
		.sdaDrive(sdaDrive), .activeBank(activeBank), .protectFlags(protectFlags),
		.writeBusy(writeBusy), .tsPointer(tsPointer), .tsData(tsData)
	);
	seb_master bus (.scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire));
	////////////////////////////////////////
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : rnd
	// Page from the high nibble, position wraps inside the page
	function automatic logic [8:0] slot(input logic [7:0] p, input int i);
		return {expBank, p[7:4], 4'(p[3:0] + i)};
	endfunction : slot
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop
	task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chkVal
	task automatic chkAck(input logic got, input logic exp);
		chkVal({15'h0000, got}, {15'h0000, exp});
	endtask : chkAck
	task automatic setHv(input logic v);
		@(posedge clk_sys);
		#1 hv = v;
	endtask : setHv
	task automatic waitIdle();
		int k;
		k = 0;
		repeat (10) @(posedge clk_sys);
		#1;
		while (writeBusy !== 1'b0 && k < 5000)
		begin
			@(posedge clk_sys);
			#1 k++;
		end
		if (k >= 5000)
		begin
			n_mismatch++;
			$display("mismatch at %0t: write cycle never ended", $time);
			report_and_stop();
		end
	endtask : waitIdle
	task automatic eeWrite(input logic [7:0] p, input int n, input logic expAck);
		bus.start();
		bus.wByte({PRE_EEPROM, addrPins, 1'b0}, a);
		chkAck(a, 1'b1);
		bus.wByte(p, a);
		chkAck(a, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			d = rnd();
			bus.wByte(d, a);
			chkAck(a, expAck);
			if (expAck)
				mem[slot(p, i)] = d;
		end
		bus.stop();
	endtask : eeWrite
	task automatic eeRead(input logic [7:0] p, input int n, input logic sel);
		bus.start();
		if (sel)
		begin
			bus.wByte({PRE_EEPROM, addrPins, 1'b0}, a);
			bus.wByte(p, a);
			chkAck(a, 1'b1);
			bus.start();
		end
		bus.wByte({PRE_EEPROM, addrPins, 1'b1}, a);
		chkAck(a, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			bus.rByte(i < n - 1, d);
			chkVal(16'(d), 16'(mem[{expBank, 8'(p + i)}]));
		end
		bus.stop();
	endtask : eeRead
	task automatic util3(input logic [2:0] sel, input logic [2:0] exp);
		bus.start();
		bus.wByte({PRE_UTILITY, sel, 1'b0}, a);
		chkAck(a, exp[2]);
		for (int i = 1; i >= 0 && a; i--)
		begin
			bus.wByte(rnd(), a);
			chkAck(a, exp[i]);
		end
		bus.stop();
	endtask : util3
	task automatic query(input logic [7:0] adr, input logic exp);
		bus.start();
		bus.wByte(adr, a);
		chkAck(a, exp);
		if (a)
		begin
			bus.rByte(1'b0, d);
			chkVal(16'(d), 16'h00FF);
		end
		bus.stop();
	endtask : query
	////////////////////////////////////////
	initial
	begin
		#900000;
		n_mismatch++;
		$display("mismatch at %0t: run timed out", $time);
		report_and_stop();
	end
	initial
	begin
		addrPins = 3'(rnd());
		for (int i = 0; i < MEM_BYTES; i++)
			mem[i] = 8'hFF;
		repeat (6) @(posedge clk_sys);
		#1 resetn = 1'b1;
		repeat (10) @(posedge clk_sys);
		#1;
		chkVal(16'(activeBank), 16'h0000);
		chkVal(16'(protectFlags), 16'h0000);
		chkVal(16'(tsPointer), 16'h0000);
		eeRead(8'h00, 2, 1'b0);
		eeWrite(8'h3E, 18, 1'b1);
		query({PRE_EEPROM, addrPins, 1'b1}, 1'b0);
		waitIdle();
		chkVal(busyLen[15:0], WRC[15:0]);
		eeRead(8'h30, 16, 1'b1);
		eeWrite(8'h00, 1, 1'b1);
		waitIdle();
		eeRead(8'hFF, 2, 1'b1);
		query({PRE_EEPROM, addrPins ^ 3'h1, 1'b1}, 1'b0);
		query({PRE_SENSOR, addrPins, 1'b1}, 1'b1);
		query({PRE_UTILITY, 3'h2, 1'b1}, 1'b0);
		query({PRE_UTILITY, SEL_PROT_BLK3, 1'b1}, 1'b1);
		d = rnd();
		w = {rnd(), rnd()};
		bus.start();
		bus.wByte({PRE_SENSOR, addrPins, 1'b0}, a);
		bus.wByte(d, a);
		bus.wByte(w[15:8], a);
		bus.wByte(w[7:0], a);
		chkAck(a, 1'b1);
		bus.stop();
		repeat (10) @(posedge clk_sys);
		chkVal(16'(tsPointer), 16'(d));
		chkVal(tsData, w);
		setHv(1'b1);
		util3(SEL_PROT_BLK0, 3'b111);
		waitIdle();
		chkVal(16'(protectFlags), 16'h0001);
		query({PRE_UTILITY, SEL_PROT_BLK0, 1'b1}, 1'b0);
		query({PRE_UTILITY, SEL_PROT_BLK1, 1'b1}, 1'b1);
		util3(SEL_PROT_BLK0, 3'b000);
		eeWrite(8'h10, 1, 1'b0);
		waitIdle();
		eeRead(8'h10, 1, 1'b1);
		setHv(1'b0);
		util3(SEL_CLEAR_ALL, 3'b110);
		waitIdle();
		chkVal(16'(protectFlags), 16'h0001);
		setHv(1'b1);
		util3(SEL_CLEAR_ALL, 3'b111);
		waitIdle();
		chkVal(16'(protectFlags), 16'h0000);
		setHv(1'b0);
		w = busyLen[15:0];
		util3(SEL_BANK_UPPER, 3'b110);
		expBank = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		chkVal(busyLen[15:0] - w, 16'h0000);
		chkVal(16'(activeBank), 16'h0001);
		query({PRE_UTILITY, SEL_BANK_LOWER, 1'b1}, 1'b0);
		eeRead(8'hFF, 2, 1'b1);
		util3(SEL_BANK_LOWER, 3'b110);
		expBank = 1'b0;
		query({PRE_UTILITY, SEL_BANK_LOWER, 1'b1}, 1'b1);
		eeRead(8'hFF, 2, 1'b1);
		report_and_stop();
	end
endmodule : test_seb_access

// File: verilog/seb_access.sv
// Slave access logic of a two-bank serial presence-detect EEPROM.
// Assumes bus pins arrive raw; clk_link oversamples them well above the bus rate.
`timescale 1ns/1ps
module seb_access
	import seb_pkg::*;
#(
	parameter int WR_CYCLES = WRITE_CYCLE_CYCLES
) (
	input  wire logic      clk_sys,
	input  wire logic      resetn,
	input  wire logic      clk_link,
	input  wire seb_pins_t pins,
	output seb_sda_drive_t sdaDrive,
	output logic           activeBank,
	output logic [3:0]     protectFlags,
	output logic           writeBusy,
	output logic [7:0]     tsPointer,
	output logic [15:0]    tsData
);
	////////////////////////////////////////////////////////////////////////////
	// Crossings between the link and system domains
	seb_pins_t  pinsS;
	seb_pins_t  pinsP;
	logic       linkRstn;
	logic       busyS;
	logic       launchTgl;
	logic       tglS;

	seb_sync #(.W(6)) uPinSync  (.clk(clk_link), .d(pins), .q(pinsS));
	seb_sync #(.W(1)) uRstSync  (.clk(clk_link), .d(resetn), .q(linkRstn));
	seb_sync #(.W(1)) uBusySync (.clk(clk_link), .d(writeBusy), .q(busyS));
	seb_sync #(.W(1)) uTglSync  (.clk(clk_sys), .d(launchTgl), .q(tglS));

	////////////////////////////////////////////////////////////////////////////
	// Link-domain protocol engine
	seb_state_t state, next_state;
	seb_cmd_t   cmd, next_cmd;
	logic [2:0] bitCnt, next_bitCnt;
	logic [7:0] shiftReg, next_shiftReg;
	logic [1:0] byteIdx, next_byteIdx;
	logic       ackBit, next_ackBit;
	logic       txDir, next_txDir;
	logic       sdaOe, next_sdaOe;
	logic [7:0] ptr, next_ptr;
	logic       next_activeBank;
	logic [3:0] next_protectFlags;
	logic [1:0] blk, next_blk;
	logic       arm, next_arm;
	logic       hvOk, next_hvOk;
	logic [15:0] bufValid, next_bufValid;
	logic [7:0] next_tsPointer;
	logic [15:0] tsStage, next_tsStage;
	logic [15:0] next_tsData;
	logic [1:0] tsCnt, next_tsCnt;
	logic       next_launchTgl;
	logic       pend, next_pend;
	logic       busyLink, sclRise, sclFall, startEv, stopEv;
	logic       byteDone, dataLoad, commit, doLoad;
	logic [7:0] rxByte, txByte;
	logic [7:0] mem [0:MEM_BYTES-1];
	logic [7:0] bufData [0:PAGE_BYTES-1];

	function automatic logic [1:0] protBlock(input logic [2:0] sel);
		case (sel)
			SEL_PROT_BLK1: protBlock = 2'h1;
			SEL_PROT_BLK2: protBlock = 2'h2;
			SEL_PROT_BLK3: protBlock = 2'h3;
			default:       protBlock = 2'h0;
		endcase
	endfunction : protBlock

	// Local pending flag covers the crossing delay before busy comes back
	assign busyLink = pend | busyS;
	assign sclRise  = pinsS.scl & ~pinsP.scl;
	assign sclFall  = ~pinsS.scl & pinsP.scl;
	assign startEv  = pinsS.scl & pinsP.scl & pinsP.sda & ~pinsS.sda;
	assign stopEv   = pinsS.scl & pinsP.scl & ~pinsP.sda & pinsS.sda;
	assign rxByte   = {shiftReg[6:0], pinsS.sda};
	assign txByte   = (cmd == CMD_EE_RD) ? mem[{activeBank, ptr}] : IDLE_TX_BYTE;

	always_comb
	begin
		next_state = state;        next_cmd = cmd;             next_bitCnt = bitCnt;
		next_shiftReg = shiftReg;  next_byteIdx = byteIdx;     next_ackBit = ackBit;
		next_txDir = txDir;        next_sdaOe = sdaOe;         next_ptr = ptr;
		next_activeBank = activeBank;
		next_protectFlags = protectFlags;
		next_blk = blk;            next_arm = arm;             next_bufValid = bufValid;
		next_tsPointer = tsPointer; next_tsStage = tsStage;    next_tsData = tsData;
		next_tsCnt = tsCnt;        next_launchTgl = launchTgl; next_pend = pend;
		next_hvOk = hvOk & pinsS.hv;
		byteDone = 1'b0;
		dataLoad = 1'b0;
		commit = 1'b0;
		doLoad = 1'b0;
		if (busyS)
			next_pend = 1'b0;
		if (startEv)
		begin
			// Repeated start keeps the pointer for a selective read
			next_state = ST_RECV;
			next_bitCnt = 3'h0;
			next_byteIdx = 2'h0;
			next_sdaOe = 1'b0;
			next_arm = 1'b0;
			next_bufValid = 16'h0000;
			next_tsCnt = 2'h0;
			next_hvOk = pinsS.hv;
		end
		else if (stopEv)
		begin
			next_state = ST_IDLE;
			next_sdaOe = 1'b0;
			if (cmd == CMD_EE_WR && bufValid != 16'h0000)
			begin
				commit = 1'b1;
				next_bufValid = 16'h0000;
				next_launchTgl = ~launchTgl;
				next_pend = 1'b1;
			end
			if (arm && hvOk)
			begin
				if (cmd == CMD_SET_PROT)
					next_protectFlags[blk] = 1'b1;
				else
					next_protectFlags = PROT_RESET;
				next_launchTgl = ~launchTgl;
				next_pend = 1'b1;
			end
			if (cmd == CMD_TS_WR && tsCnt == 2'h2)
				next_tsData = tsStage;
			next_arm = 1'b0;
		end
		else
		begin
			case (state)
				ST_RECV:
					if (sclRise)
					begin
						next_shiftReg = rxByte;
						next_bitCnt = bitCnt + 3'h1;
						if (bitCnt == 3'h7)
						begin
							byteDone = 1'b1;
							next_state = ST_ACK1;
							next_byteIdx = (byteIdx == 2'h2) ? 2'h2 : byteIdx + 2'h1;
							next_ackBit = 1'b0;
							if (byteIdx == 2'h0)
							begin
								next_txDir = rxByte[0];
								next_cmd = CMD_NONE;
								// Pins decide only sensor and EEPROM access
								if (rxByte[7:4] == PRE_EEPROM && rxByte[3:1] == pinsS.addr)
								begin
									next_cmd = rxByte[0] ? CMD_EE_RD : CMD_EE_WR;
									next_ackBit = ~busyLink;
								end
								else if (rxByte[7:4] == PRE_SENSOR && rxByte[3:1] == pinsS.addr)
								begin
									next_cmd = rxByte[0] ? CMD_TS_RD : CMD_TS_WR;
									next_ackBit = 1'b1;
								end
								else if (rxByte[7:4] == PRE_UTILITY && !busyLink)
								begin
									case (rxByte[3:1])
										SEL_PROT_BLK0, SEL_PROT_BLK1, SEL_PROT_BLK2, SEL_PROT_BLK3:
										begin
											next_cmd = rxByte[0] ? CMD_QUERY_PROT : CMD_SET_PROT;
											next_blk = protBlock(rxByte[3:1]);
											next_ackBit = ~protectFlags[protBlock(rxByte[3:1])];
										end
										SEL_CLEAR_ALL:
										begin
											next_cmd = rxByte[0] ? CMD_NONE : CMD_CLEAR_PROT;
											next_ackBit = ~rxByte[0];
										end
										SEL_BANK_LOWER:
										begin
											next_cmd = rxByte[0] ? CMD_QUERY_BANK : CMD_SEL_LOWER;
											next_ackBit = rxByte[0] ? ~activeBank : 1'b1;
										end
										SEL_BANK_UPPER:
										begin
											next_cmd = rxByte[0] ? CMD_NONE : CMD_SEL_UPPER;
											next_ackBit = ~rxByte[0];
										end
										default: next_cmd = CMD_NONE;
									endcase
								end
							end
							else if (byteIdx == 2'h1)
							begin
								case (cmd)
									CMD_EE_WR:
									begin
										next_ptr = rxByte;
										next_ackBit = 1'b1;
									end
									CMD_TS_WR:
									begin
										next_tsPointer = rxByte;
										next_ackBit = 1'b1;
									end
									CMD_SET_PROT, CMD_CLEAR_PROT, CMD_SEL_LOWER, CMD_SEL_UPPER:
										next_ackBit = 1'b1;
									default: next_ackBit = 1'b0;
								endcase
							end
							else
							begin
								case (cmd)
									CMD_EE_WR:
									begin
										next_ackBit = ~protectFlags[{activeBank, ptr[7]}];
										if (!protectFlags[{activeBank, ptr[7]}])
										begin
											dataLoad = 1'b1;
											next_bufValid[ptr[3:0]] = 1'b1;
											next_ptr[3:0] = ptr[3:0] + 4'h1;
										end
									end
									CMD_TS_WR:
									begin
										next_tsStage = {tsStage[7:0], rxByte};
										next_tsCnt = (tsCnt == 2'h2) ? 2'h2 : tsCnt + 2'h1;
										next_ackBit = 1'b1;
									end
									CMD_SET_PROT, CMD_CLEAR_PROT:
									begin
										next_ackBit = hvOk;
										next_arm = hvOk;
									end
									CMD_SEL_LOWER, CMD_SEL_UPPER:
										// Bank flips without a write cycle
										next_activeBank = (cmd == CMD_SEL_UPPER);
									default: next_ackBit = 1'b0;
								endcase
							end
						end
					end
				ST_ACK1:
					if (sclFall)
					begin
						next_sdaOe = ackBit;
						next_state = ST_ACK2;
					end
				ST_ACK2:
					if (sclFall)
					begin
						next_sdaOe = 1'b0;
						next_bitCnt = 3'h0;
						if (!ackBit)
							next_state = ST_IDLE;
						else if (txDir)
							doLoad = 1'b1;
						else
							next_state = ST_RECV;
					end
				ST_SEND:
					if (sclFall)
					begin
						if (bitCnt == 3'h7)
						begin
							next_sdaOe = 1'b0;
							next_state = ST_MACK1;
						end
						else
						begin
							next_shiftReg = {shiftReg[6:0], 1'b1};
							next_sdaOe = ~shiftReg[6];
							next_bitCnt = bitCnt + 3'h1;
						end
					end
				ST_MACK1:
					if (sclRise)
					begin
						next_ackBit = ~pinsS.sda;
						next_state = ST_MACK2;
					end
				ST_MACK2:
					if (sclFall)
					begin
						// Master NACK ends the read
						if (ackBit)
							doLoad = 1'b1;
						else
							next_state = ST_IDLE;
					end
				default: next_state = ST_IDLE;
			endcase
			if (doLoad)
			begin
				next_shiftReg = txByte;
				next_sdaOe = ~txByte[7];
				next_bitCnt = 3'h0;
				next_state = ST_SEND;
				if (cmd == CMD_EE_RD)
					next_ptr = ptr + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_link)
	begin
		pinsP <= pinsS;
		if (!linkRstn)
		begin
			state <= ST_IDLE;    cmd <= CMD_NONE;      bitCnt <= 3'h0;
			shiftReg <= 8'h00;   byteIdx <= 2'h0;      ackBit <= 1'b0;
			txDir <= 1'b0;       sdaOe <= 1'b0;        ptr <= PTR_RESET;
			activeBank <= BANK_RESET;
			protectFlags <= PROT_RESET;
			blk <= 2'h0;         arm <= 1'b0;          hvOk <= 1'b0;
			bufValid <= 16'h0000;
			tsPointer <= PTR_RESET;
			tsStage <= 16'h0000; tsData <= 16'h0000;   tsCnt <= 2'h0;
			launchTgl <= 1'b0;   pend <= 1'b0;
		end
		else
		begin
			state <= next_state; cmd <= next_cmd;      bitCnt <= next_bitCnt;
			shiftReg <= next_shiftReg;                 byteIdx <= next_byteIdx;
			ackBit <= next_ackBit;                     txDir <= next_txDir;
			sdaOe <= next_sdaOe; ptr <= next_ptr;      activeBank <= next_activeBank;
			protectFlags <= next_protectFlags;         blk <= next_blk;
			arm <= next_arm;     hvOk <= next_hvOk;    bufValid <= next_bufValid;
			tsPointer <= next_tsPointer;               tsStage <= next_tsStage;
			tsData <= next_tsData;                     tsCnt <= next_tsCnt;
			launchTgl <= next_launchTgl;               pend <= next_pend;
		end
	end

	// Open drain: the data level is fixed low, only the enable moves
	assign sdaDrive = '{sdaOut: 1'b0, sdaOe: sdaOe};

	// Array is wide but keeps the erased state under reset
	always_ff @(posedge clk_link)
	begin
		if (!linkRstn)
		begin
			for (int i = 0; i < MEM_BYTES; i++)
				mem[i] <= ERASED_BYTE;
		end
		else
		begin
			if (dataLoad)
				bufData[ptr[3:0]] <= rxByte;
			if (commit)
				for (int i = 0; i < PAGE_BYTES; i++)
					if (bufValid[i])
						mem[{activeBank, ptr[7:4], 4'(i)}] <= bufData[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// System-domain write cycle timer
	logic                tglSeen;
	logic                launch;
	logic [WR_CNT_W-1:0] wrCnt, next_wrCnt;
	logic [WR_CNT_W-1:0] busyLen;

	assign launch = tglS ^ tglSeen;

	always_comb
	begin
		next_wrCnt = wrCnt;
		if (launch)
			next_wrCnt = WR_CNT_W'(WR_CYCLES);
		else if (wrCnt != '0)
			next_wrCnt = wrCnt - 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			tglSeen <= 1'b0;
			wrCnt <= '0;
			writeBusy <= 1'b0;
			busyLen <= '0;
		end
		else
		begin
			tglSeen <= tglS;
			wrCnt <= next_wrCnt;
			writeBusy <= (next_wrCnt != '0);
			busyLen <= writeBusy ? busyLen + 1'b1 : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_addrDone;
		byteDone && byteIdx == 2'h0;
	endsequence
	sequence s_thirdDone;
		byteDone && byteIdx == 2'h2;
	endsequence

	property p_power_up;
		@(posedge clk_link) disable iff (!linkRstn)
		$rose(linkRstn) |-> ptr == PTR_RESET && tsPointer == PTR_RESET
			&& activeBank == BANK_RESET && protectFlags == PROT_RESET;
	endproperty
	a_power_up: assert property (p_power_up) else $error("bad power-up state");
	property p_busy_poll;
		@(posedge clk_link) disable iff (!linkRstn)
		s_addrDone ##0 (next_cmd == CMD_EE_RD || next_cmd == CMD_EE_WR) && busyLink
			|=> !ackBit ##1 (state == ST_ACK1);
	endproperty
	a_busy_poll: assert property (p_busy_poll) else $error("address acked while busy");
	property p_bank_select;
		@(posedge clk_link) disable iff (!linkRstn)
		s_thirdDone ##0 (cmd == CMD_SEL_LOWER || cmd == CMD_SEL_UPPER)
			|=> activeBank == $past(cmd == CMD_SEL_UPPER) && !ackBit && !pend;
	endproperty
	a_bank_select: assert property (p_bank_select) else $error("bank select wrong");
	property p_page_wrap;
		@(posedge clk_link) disable iff (!linkRstn)
		dataLoad |=> ptr[3:0] == $past(ptr[3:0]) + 4'h1 && ptr[7:4] == $past(ptr[7:4]);
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page position wrong");
	property p_read_inc;
		@(posedge clk_link) disable iff (!linkRstn)
		doLoad && cmd == CMD_EE_RD |=> ptr == $past(ptr) + 8'h01
			&& sdaOe == !$past(txByte[7]) && state == ST_SEND;
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read pointer wrong");
	property p_prot_query;
		@(posedge clk_link) disable iff (!linkRstn)
		s_addrDone ##0 next_cmd == CMD_QUERY_PROT |=> ackBit == !protectFlags[blk];
	endproperty
	a_prot_query: assert property (p_prot_query) else $error("protect query wrong");
	property p_bank_query;
		@(posedge clk_link) disable iff (!linkRstn)
		s_addrDone ##0 next_cmd == CMD_QUERY_BANK |=> ackBit == !activeBank;
	endproperty
	a_bank_query: assert property (p_bank_query) else $error("bank query wrong");
	property p_guarded;
		@(posedge clk_link) disable iff (!linkRstn)
		s_thirdDone ##0 cmd == CMD_EE_WR && protectFlags[{activeBank, ptr[7]}]
			|=> !ackBit && $stable(bufValid);
	endproperty
	a_guarded: assert property (p_guarded) else $error("guarded byte taken");
	property p_no_hv;
		@(posedge clk_link) disable iff (!linkRstn)
		s_thirdDone ##0 (cmd == CMD_SET_PROT || cmd == CMD_CLEAR_PROT) && !hvOk
			|=> !ackBit && !arm;
	endproperty
	a_no_hv: assert property (p_no_hv) else $error("change without high voltage");
	property p_stop_launch;
		@(posedge clk_link) disable iff (!linkRstn)
		stopEv && cmd == CMD_EE_WR && bufValid != 16'h0000
			|=> launchTgl != $past(launchTgl) && pend && bufValid == 16'h0000;
	endproperty
	a_stop_launch: assert property (p_stop_launch) else $error("no write launch");
	property p_busy_len;
		@(posedge clk_sys) disable iff (!resetn)
		$fell(writeBusy) |-> busyLen == WR_CNT_W'(WR_CYCLES);
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule : seb_access

// File: verilog/seb_pkg.sv
// Shared constants and types of the serial EEPROM bank access block.
// Assumes the block sits behind a two-wire bus front end with open-drain data.
package seb_pkg;
	// Write cycle time, rounded up to whole system clocks
	localparam int CLK_SYS_PERIOD_NS  = 10;
	localparam int WRITE_CYCLE_NS     = 5000;
	localparam int WRITE_CYCLE_CYCLES = (WRITE_CYCLE_NS + CLK_SYS_PERIOD_NS - 1)
		/ CLK_SYS_PERIOD_NS;
	localparam int WR_CNT_W           = 16;

	// Memory geometry
	localparam int PAGE_BYTES = 16;
	localparam int MEM_BYTES  = 512;

	// Slave address preambles
	localparam logic [3:0] PRE_EEPROM  = 4'hA;
	localparam logic [3:0] PRE_SENSOR  = 4'h3;
	localparam logic [3:0] PRE_UTILITY = 4'h6;

	// Utility select codes, address bits 3..1
	localparam logic [2:0] SEL_PROT_BLK0  = 3'h1;
	localparam logic [2:0] SEL_PROT_BLK1  = 3'h4;
	localparam logic [2:0] SEL_PROT_BLK2  = 3'h5;
	localparam logic [2:0] SEL_PROT_BLK3  = 3'h0;
	localparam logic [2:0] SEL_CLEAR_ALL  = 3'h3;
	localparam logic [2:0] SEL_BANK_LOWER = 3'h6;
	localparam logic [2:0] SEL_BANK_UPPER = 3'h7;

	// Reset and fill values
	localparam logic [7:0] ERASED_BYTE  = 8'hFF;
	localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
	localparam logic [7:0] PTR_RESET    = 8'h00;
	localparam logic       BANK_RESET   = 1'b0;
	localparam logic [3:0] PROT_RESET   = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_RECV  = 3'b001,
		ST_ACK1  = 3'b010,
		ST_ACK2  = 3'b011,
		ST_SEND  = 3'b100,
		ST_MACK1 = 3'b101,
		ST_MACK2 = 3'b110
	} seb_state_t;

	typedef enum logic [3:0] {
		CMD_NONE       = 4'h0,
		CMD_EE_WR      = 4'h1,
		CMD_EE_RD      = 4'h2,
		CMD_TS_WR      = 4'h3,
		CMD_TS_RD      = 4'h4,
		CMD_SET_PROT   = 4'h5,
		CMD_CLEAR_PROT = 4'h6,
		CMD_QUERY_PROT = 4'h7,
		CMD_SEL_LOWER  = 4'h8,
		CMD_SEL_UPPER  = 4'h9,
		CMD_QUERY_BANK = 4'hA
	} seb_cmd_t;

	// Pins from the bus; hv is the high_voltage_unlock detector on addr_pin_lsb
	typedef struct packed {
		logic       hv;
		logic [2:0] addr;
		logic       sda;
		logic       scl;
	} seb_pins_t;

	typedef struct packed {
		logic sdaOut;
		logic sdaOe;
	} seb_sda_drive_t;
endpackage : seb_pkg

// File: verilog/seb_sync.sv
// Two flip-flop synchroniser for levels entering a clock domain.
// Assumes each bit is a level or a toggle; buses need their own handshake.
`timescale 1ns/1ps
module seb_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;

	// First stage feeds only the second one
	always_ff @(posedge clk)
	begin
		stage1 <= d;
		q      <= stage1;
	end
endmodule : seb_sync
